// >>> hw/siu_pkg.sv
// constants, types and register map for the stack instruction unit
// assumes an apb master and a word-wide stack memory with an ack handshake
//
// Overview of operation
// - no-load negate keeps the destination and restores carry, still tests skip
// - negate words ending 1000 or 1001 are rejected as not negate
// - skip field gives never, always, carry, result and combined tests
// - a true skip advances the program counter by exactly one more word
// - flag-only i/o sets the device busy/done flags by function, no data
// - translation op with translation off translates exactly one memory access
// - translation op turns translation off when on and both modes disabled
// - multi-word unstack pops from source down to destination, three after zero
// - multi-word unstack lowers stack pointer by the count, frame pointer kept
// - block unstack pops carry/pc then accumulators three to zero
// - unstack-and-branch loads pc from top word, sp minus one
// - multi-word stack store pushes source up to destination, zero after three
// - stack store raises sp by count, overflow checked once at the end
// - stack-and-branch pushes next address then jumps to the effective address
// - stack-return-address pushes its own address plus two
// - switch register fetch copies the switches into the accumulator
// - context unstack pops nine words ending with frame and stack pointers
// - subroutine exit pops a five-word block starting at the frame pointer
// - subroutine exit sets sp to decremented fp and fp to popped three
// - subroutine entry sets fp and accumulator three to the sp after the pushes, then adds frame to sp
// - entry block pushes accumulators zero, one, two then old frame pointer
// - fifth entry word holds carry on top and accumulator three below
// - stack overflow at subroutine entry jumps to the stack fault handler
// - negate with no-load clear writes the shifted result to destination
package siu_pkg;
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_INSTR = 8'h04;
  localparam logic [7:0] A_OPND = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_PC = 8'h10;
  localparam logic [7:0] A_SP = 8'h14;
  localparam logic [7:0] A_FP = 8'h18;
  localparam logic [7:0] A_SL = 8'h1c;
  localparam logic [7:0] A_SFA = 8'h20;
  localparam logic [7:0] A_ACC0 = 8'h24;
  localparam logic [7:0] A_ACC3 = 8'h30;
  localparam logic [3:0] AC_WORD0 = 4'h9;
  localparam logic [3:0] BLK_WORDS = 4'h5;
  localparam logic [3:0] CTX_WORDS = 4'h9;
  localparam logic [15:0] RST_SL = 16'hffff;

  typedef enum logic [3:0] {
    OP_NONE, OP_TWOS, OP_FLAG_IO, OP_XLAT, OP_UNSTACK, OP_BLK_UNSTACK,
    OP_UNSTACK_BR, OP_STACK, OP_STACK_BR, OP_STACK_RET, OP_SWITCH,
    OP_CTX_UNSTACK, OP_SUB_EXIT, OP_SUB_ENTRY
  } siu_op_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_GO, ST_IND, ST_PUSH, ST_POP, ST_FIN
  } siu_state_t;

  typedef struct packed {
    siu_state_t state;
    siu_op_t op;
    logic [1:0] acs;
    logic [1:0] acd;
    logic [1:0] fn;
    logic [1:0] idx;
    logic [15:0] instr;
    logic [15:0] opnd;
    logic [3:0] k;
    logic [3:0] cnt;
    logic [15:0] ea;
    logic [15:0] sp0;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] fp;
    logic [15:0] sl;
    logic [15:0] sfa;
    logic [3:0][15:0] ac;
    logic carry;
    logic xlat_en;
    logic xlat_once;
    logic err;
    logic fault;
    logic mem_req;
    logic mem_we;
    logic mem_xlat;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic io_stb;
    logic [5:0] io_dev;
    logic [1:0] io_fn;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } siu_st_t;

  localparam siu_st_t RST_ST = '{state: ST_IDLE, op: OP_NONE, sl: RST_SL,
                                 default: '0};
endpackage : siu_pkg

// >>> hw/siu_twos_unit.sv
// negate datapath: carry init, two's complement, shift and skip test
// assumes the caller holds word, source and carry stable for the cycle
`timescale 1ns/1ps
`default_nettype none
module siu_twos_unit (
  input wire logic [15:0] i_word, // negate instruction word
  input wire logic [15:0] i_src, // source accumulator
  input wire logic i_carry, // carry before the instruction
  output logic o_valid, // word decodes as a negate
  output logic o_load, // result goes to the destination
  output logic [15:0] o_res, // shifted result
  output logic o_carry, // carry after the instruction
  output logic o_skip // skip test is true
);
  logic c0;
  logic z;
  logic [16:0] sum;
  logic [16:0] sh;

  always_comb begin
    o_valid = i_word[15] && (i_word[10:8] == 3'h1) &&
              !(i_word[3] && (i_word[2:1] == 2'h0));
    case (i_word[5:4])
      2'h0: c0 = i_carry;
      2'h1: c0 = 1'h0;
      2'h2: c0 = 1'h1;
      default: c0 = !i_carry;
    endcase
    sum = {1'h0, ~i_src} + 17'h0_0001;
    // carry out of the msb only happens for a zero source
    if (sum[16]) begin
      c0 = !c0;
    end
    case (i_word[7:6])
      2'h1: sh = {sum[15:0], c0};
      2'h2: sh = {sum[0], c0, sum[15:1]};
      2'h3: sh = {c0, sum[7:0], sum[15:8]};
      default: sh = {c0, sum[15:0]};
    endcase
    z = (sh[15:0] == 16'h0000);
    case (i_word[2:0])
      3'h0: o_skip = 1'h0;
      3'h1: o_skip = 1'h1;
      3'h2: o_skip = !sh[16];
      3'h3: o_skip = sh[16];
      3'h4: o_skip = z;
      3'h5: o_skip = !z;
      3'h6: o_skip = !sh[16] || z;
      default: o_skip = sh[16] && !z;
    endcase
    o_load = !i_word[3];
    o_carry = i_word[3] ? i_carry : sh[16];
    o_res = sh[15:0];
  end
endmodule : siu_twos_unit
`default_nettype wire

// >>> hw/siu_stack_unit.sv
// stack instruction unit: runs one command at a time against a stack memory
// assumes an apb master, and a memory that acks each request once
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module siu_stack_unit (
  input wire logic i_mclk, // 25 mhz clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb access phase
  input wire logic i_pwrite, // apb write
  input wire logic [7:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error on unmapped address
  output logic o_mem_req, // memory request, held until ack
  output logic o_mem_we, // memory write
  output logic o_mem_xlat, // apply user translation to this access
  output logic [15:0] o_mem_addr, // memory word address
  output logic [15:0] o_mem_wdata, // memory write data
  input wire logic [15:0] i_mem_rdata, // read data, valid with ack
  input wire logic i_mem_ack, // one-cycle completion
  input wire logic [15:0] i_switch, // front panel switch register
  input wire logic i_ld_eff_mode, // load-effective mode active
  input wire logic i_io_prot, // i/o protection active
  output logic o_io_stb, // flag-only i/o pulse
  output logic [5:0] o_io_dev, // addressed peripheral
  output logic [1:0] o_io_fn // busy/done function
);
  siu_pkg::siu_st_t st_ff;
  siu_pkg::siu_st_t nxt_st;
  logic neg_ok;
  logic neg_ld;
  logic neg_c;
  logic neg_skip;
  logic [15:0] neg_res;
  logic [1:0] ridx;
  logic [15:0] new_sp;
  logic [15:0] base;

  siu_twos_unit siu_twos_unit_i (
    .i_word(st_ff.instr),
    .i_src(st_ff.ac[st_ff.instr[14:13]]),
    .i_carry(st_ff.carry),
    .o_valid(neg_ok),
    .o_load(neg_ld),
    .o_res(neg_res),
    .o_carry(neg_c),
    .o_skip(neg_skip)
  );

  function automatic logic [3:0] span(input logic [1:0] from,
                                      input logic [1:0] to);
    span = {2'h0, 2'(to - from)} + 4'h1;
  endfunction : span

  function automatic logic hit(input logic [7:0] a);
    hit = (a[1:0] == 2'h0) && (a <= siu_pkg::A_ACC3);
  endfunction : hit

  function automatic logic [15:0] push_word(input siu_pkg::siu_st_t s);
    case (s.op)
      siu_pkg::OP_STACK: begin
        push_word = s.ac[2'(s.acs + s.k[1:0])];
      end
      siu_pkg::OP_SUB_ENTRY: begin
        if (s.k == 4'h3) begin
          push_word = s.fp;
        end else if (s.k == 4'h4) begin
          push_word = {s.carry, s.ac[3][14:0]};
        end else begin
          push_word = s.ac[s.k[1:0]];
        end
      end
      // both branch-and-stack forms are two-word instructions
      default: push_word = 16'(s.pc + 16'h0002);
    endcase
  endfunction : push_word

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pready = 1'h0;
    nxt_st.pslverr = 1'h0;
    nxt_st.io_stb = 1'h0;
    ridx = 2'(i_paddr[5:2] - siu_pkg::AC_WORD0);
    new_sp = 16'(st_ff.sp + st_ff.opnd);
    case (st_ff.idx)
      2'h1: base = st_ff.pc;
      2'h2: base = st_ff.ac[2];
      2'h3: base = st_ff.ac[3];
      default: base = 16'h0000;
    endcase
    // setup phase: answer is registered, so pready rises in the access phase
    if (i_psel && !i_penable) begin
      nxt_st.pready = 1'h1;
      nxt_st.pslverr = !hit(i_paddr);
      case (i_paddr)
        siu_pkg::A_CMD: nxt_st.prdata = {20'h0_0000, st_ff.idx, st_ff.fn,
                                         st_ff.acd, st_ff.acs, st_ff.op};
        siu_pkg::A_INSTR: nxt_st.prdata = {16'h0000, st_ff.instr};
        siu_pkg::A_OPND: nxt_st.prdata = {16'h0000, st_ff.opnd};
        siu_pkg::A_STAT: nxt_st.prdata = {26'h000_0000, st_ff.fault,
                                          st_ff.err, st_ff.xlat_once,
                                          st_ff.xlat_en, st_ff.carry,
                                          st_ff.state != siu_pkg::ST_IDLE};
        siu_pkg::A_PC: nxt_st.prdata = {16'h0000, st_ff.pc};
        siu_pkg::A_SP: nxt_st.prdata = {16'h0000, st_ff.sp};
        siu_pkg::A_FP: nxt_st.prdata = {16'h0000, st_ff.fp};
        siu_pkg::A_SL: nxt_st.prdata = {16'h0000, st_ff.sl};
        siu_pkg::A_SFA: nxt_st.prdata = {16'h0000, st_ff.sfa};
        default: begin
          if (hit(i_paddr)) begin
            nxt_st.prdata = {16'h0000, st_ff.ac[ridx]};
          end else begin
            nxt_st.prdata = 32'h0000_0000;
          end
        end
      endcase
    end
    // writes land only while idle so software never races the engine
    if (i_psel && i_penable && st_ff.pready && i_pwrite &&
        st_ff.state == siu_pkg::ST_IDLE) begin
      case (i_paddr)
        siu_pkg::A_CMD: begin
          nxt_st.op = siu_pkg::siu_op_t'(i_pwdata[3:0]);
          nxt_st.acs = i_pwdata[5:4];
          nxt_st.acd = i_pwdata[7:6];
          nxt_st.fn = i_pwdata[9:8];
          nxt_st.idx = i_pwdata[11:10];
          nxt_st.err = 1'h0;
          nxt_st.state = siu_pkg::ST_GO;
        end
        siu_pkg::A_INSTR: nxt_st.instr = i_pwdata[15:0];
        siu_pkg::A_OPND: nxt_st.opnd = i_pwdata[15:0];
        siu_pkg::A_STAT: begin
          nxt_st.carry = i_pwdata[1];
          nxt_st.xlat_en = i_pwdata[2];
          nxt_st.xlat_once = i_pwdata[3];
          nxt_st.err = st_ff.err && !i_pwdata[4];
          nxt_st.fault = st_ff.fault && !i_pwdata[5];
        end
        siu_pkg::A_PC: nxt_st.pc = i_pwdata[15:0];
        siu_pkg::A_SP: nxt_st.sp = i_pwdata[15:0];
        siu_pkg::A_FP: nxt_st.fp = i_pwdata[15:0];
        siu_pkg::A_SL: nxt_st.sl = i_pwdata[15:0];
        siu_pkg::A_SFA: nxt_st.sfa = i_pwdata[15:0];
        default: begin
          if (hit(i_paddr)) begin
            nxt_st.ac[ridx] = i_pwdata[15:0];
          end
        end
      endcase
    end
    case (st_ff.state)
      siu_pkg::ST_IDLE: begin
      end
      siu_pkg::ST_GO: begin
        nxt_st.sp0 = st_ff.sp;
        nxt_st.k = 4'h0;
        nxt_st.state = siu_pkg::ST_IDLE;
        case (st_ff.op)
          siu_pkg::OP_TWOS: begin
            if (neg_ok) begin
              if (neg_ld) begin
                nxt_st.ac[st_ff.instr[12:11]] = neg_res;
              end
              nxt_st.carry = neg_c;
              nxt_st.pc = 16'(st_ff.pc +
                              (neg_skip ? 16'h0002 : 16'h0001));
            end else begin
              nxt_st.err = 1'h1;
            end
          end
          siu_pkg::OP_FLAG_IO: begin
            nxt_st.io_stb = 1'h1;
            nxt_st.io_dev = st_ff.instr[5:0];
            nxt_st.io_fn = st_ff.fn;
            nxt_st.pc = 16'(st_ff.pc + 16'h0001);
          end
          siu_pkg::OP_XLAT: begin
            if (!st_ff.xlat_en) begin
              nxt_st.xlat_once = 1'h1;
            end else if (!i_ld_eff_mode && !i_io_prot) begin
              nxt_st.xlat_en = 1'h0;
            end
            nxt_st.pc = 16'(st_ff.pc + 16'h0001);
          end
          siu_pkg::OP_SWITCH: begin
            nxt_st.ac[st_ff.acd] = i_switch;
            nxt_st.pc = 16'(st_ff.pc + 16'h0001);
          end
          siu_pkg::OP_UNSTACK: begin
            nxt_st.cnt = span(st_ff.acd, st_ff.acs);
            nxt_st.state = siu_pkg::ST_POP;
          end
          siu_pkg::OP_BLK_UNSTACK: begin
            nxt_st.cnt = siu_pkg::BLK_WORDS;
            nxt_st.state = siu_pkg::ST_POP;
          end
          siu_pkg::OP_UNSTACK_BR: begin
            nxt_st.cnt = 4'h1;
            nxt_st.state = siu_pkg::ST_POP;
          end
          siu_pkg::OP_CTX_UNSTACK: begin
            nxt_st.cnt = siu_pkg::CTX_WORDS;
            nxt_st.state = siu_pkg::ST_POP;
          end
          siu_pkg::OP_SUB_EXIT: begin
            nxt_st.sp = st_ff.fp;
            nxt_st.sp0 = st_ff.fp;
            nxt_st.cnt = siu_pkg::BLK_WORDS;
            nxt_st.state = siu_pkg::ST_POP;
          end
          siu_pkg::OP_STACK: begin
            nxt_st.cnt = span(st_ff.acs, st_ff.acd);
            nxt_st.state = siu_pkg::ST_PUSH;
          end
          siu_pkg::OP_STACK_RET: begin
            nxt_st.cnt = 4'h1;
            nxt_st.state = siu_pkg::ST_PUSH;
          end
          siu_pkg::OP_SUB_ENTRY: begin
            nxt_st.cnt = siu_pkg::BLK_WORDS;
            nxt_st.state = siu_pkg::ST_PUSH;
          end
          siu_pkg::OP_STACK_BR: begin
            nxt_st.cnt = 4'h1;
            nxt_st.ea = 16'(base + {st_ff.opnd[14], st_ff.opnd[14:0]});
            if (st_ff.idx == 2'h0) begin
              nxt_st.ea = {1'h0, st_ff.opnd[14:0]};
            end
            nxt_st.state = st_ff.opnd[15] ? siu_pkg::ST_IND
                                          : siu_pkg::ST_PUSH;
          end
          default: nxt_st.err = 1'h1;
        endcase
      end
      siu_pkg::ST_IND, siu_pkg::ST_PUSH, siu_pkg::ST_POP: begin
        if (!st_ff.mem_req) begin
          nxt_st.mem_req = 1'h1;
          nxt_st.mem_xlat = st_ff.xlat_en || st_ff.xlat_once;
          nxt_st.mem_we = (st_ff.state == siu_pkg::ST_PUSH);
          nxt_st.mem_wdata = push_word(st_ff);
          case (st_ff.state)
            siu_pkg::ST_IND: nxt_st.mem_addr = st_ff.ea;
            siu_pkg::ST_PUSH: nxt_st.mem_addr = 16'(st_ff.sp + 16'h0001);
            default: nxt_st.mem_addr = st_ff.sp;
          endcase
        end else if (i_mem_ack) begin
          nxt_st.mem_req = 1'h0;
          nxt_st.mem_we = 1'h0;
          if (st_ff.mem_xlat) begin
            nxt_st.xlat_once = 1'h0;
          end
          nxt_st.k = st_ff.k + 4'h1;
          if (st_ff.k == 4'(st_ff.cnt - 4'h1)) begin
            nxt_st.state = siu_pkg::ST_FIN;
          end
          case (st_ff.state)
            siu_pkg::ST_IND: begin
              nxt_st.ea = i_mem_rdata;
              nxt_st.k = 4'h0;
              nxt_st.state = siu_pkg::ST_PUSH;
            end
            siu_pkg::ST_PUSH: nxt_st.sp = 16'(st_ff.sp + 16'h0001);
            default: begin
              nxt_st.sp = 16'(st_ff.sp - 16'h0001);
              case (st_ff.op)
                siu_pkg::OP_UNSTACK: begin
                  nxt_st.ac[2'(st_ff.acs - st_ff.k[1:0])] = i_mem_rdata;
                end
                siu_pkg::OP_UNSTACK_BR: nxt_st.pc = i_mem_rdata;
                default: begin
                  case (st_ff.k)
                    4'h0: begin
                      nxt_st.carry = i_mem_rdata[15];
                      nxt_st.pc = {1'h0, i_mem_rdata[14:0]};
                    end
                    4'h5: nxt_st.sfa = i_mem_rdata;
                    4'h6: nxt_st.sl = i_mem_rdata;
                    4'h7: nxt_st.fp = i_mem_rdata;
                    4'h8: nxt_st.sp = i_mem_rdata;
                    default: begin
                      nxt_st.ac[2'(3'h4 - st_ff.k[2:0])] = i_mem_rdata;
                    end
                  endcase
                end
              endcase
            end
          endcase
        end
      end
      siu_pkg::ST_FIN: begin
        nxt_st.state = siu_pkg::ST_IDLE;
        case (st_ff.op)
          siu_pkg::OP_UNSTACK: nxt_st.pc = 16'(st_ff.pc + 16'h0001);
          siu_pkg::OP_SUB_EXIT: nxt_st.fp = st_ff.ac[3];
          siu_pkg::OP_SUB_ENTRY: begin
            nxt_st.fp = st_ff.sp;
            nxt_st.ac[3] = st_ff.sp;
            nxt_st.sp = new_sp;
            nxt_st.pc = 16'(st_ff.pc + 16'h0002);
            if (new_sp > st_ff.sl) begin
              nxt_st.fault = 1'h1;
              nxt_st.pc = st_ff.sfa;
            end
          end
          siu_pkg::OP_STACK, siu_pkg::OP_STACK_RET,
          siu_pkg::OP_STACK_BR: begin
            if (st_ff.op == siu_pkg::OP_STACK) begin
              nxt_st.pc = 16'(st_ff.pc + 16'h0001);
            end else if (st_ff.op == siu_pkg::OP_STACK_RET) begin
              nxt_st.pc = 16'(st_ff.pc + 16'h0002);
            end else begin
              nxt_st.pc = st_ff.ea;
            end
            // one check after the whole push, never per word
            if (st_ff.sp > st_ff.sl) begin
              nxt_st.fault = 1'h1;
              nxt_st.pc = st_ff.sfa;
            end
          end
          default: begin
          end
        endcase
      end
      default: nxt_st.state = siu_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= siu_pkg::RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_prdata = st_ff.prdata;
  assign o_pready = st_ff.pready;
  assign o_pslverr = st_ff.pslverr;
  assign o_mem_req = st_ff.mem_req;
  assign o_mem_we = st_ff.mem_we;
  assign o_mem_xlat = st_ff.mem_xlat;
  assign o_mem_addr = st_ff.mem_addr;
  assign o_mem_wdata = st_ff.mem_wdata;
  assign o_io_stb = st_ff.io_stb;
  assign o_io_dev = st_ff.io_dev;
  assign o_io_fn = st_ff.io_fn;

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic go_twos;
  logic in_go;
  logic [15:0] acd_val;
  logic [15:0] ac3_val;
  assign in_go = (st_ff.state == siu_pkg::ST_GO);
  assign go_twos = in_go && st_ff.op == siu_pkg::OP_TWOS && neg_ok;
  assign acd_val = st_ff.ac[st_ff.instr[12:11]];
  assign ac3_val = st_ff.ac[3];

  sequence s_pop_ack;
    st_ff.state == siu_pkg::ST_POP && st_ff.mem_req && i_mem_ack;
  endsequence
  sequence s_fin(siu_pkg::siu_op_t o);
    st_ff.state == siu_pkg::ST_FIN && st_ff.op == o;
  endsequence

  noload_keep_a: assert property (go_twos && st_ff.instr[3] |=>
    acd_val == $past(acd_val) && st_ff.carry == $past(st_ff.carry))
    else $error("no-load negate changed destination or carry");
  neg_reject_a: assert property (in_go && st_ff.op == siu_pkg::OP_TWOS &&
    st_ff.instr[15] && st_ff.instr[10:8] == 3'h1 && st_ff.instr[3] &&
    st_ff.instr[2:1] == 2'h0 |=> st_ff.err && st_ff.pc == $past(st_ff.pc))
    else $error("reserved negate pattern was executed");
  skip_count_a: assert property (go_twos && neg_skip |=>
    st_ff.pc == 16'($past(st_ff.pc) + 16'h0002))
    else $error("skip did not advance pc by two words");
  flag_io_a: assert property (in_go && st_ff.op == siu_pkg::OP_FLAG_IO |=>
    o_io_stb && o_io_dev == st_ff.instr[5:0] ##1 !o_io_stb)
    else $error("flag-only i/o pulse wrong");
  xlat_off_a: assert property (in_go && st_ff.op == siu_pkg::OP_XLAT &&
    st_ff.xlat_en && !i_ld_eff_mode && !i_io_prot |=> !st_ff.xlat_en)
    else $error("translation not disabled");
  xlat_once_a: assert property (st_ff.mem_req && i_mem_ack &&
    st_ff.mem_xlat && !st_ff.xlat_en |=> !st_ff.xlat_once)
    else $error("single-cycle translation outlived one access");
  pop_sp_a: assert property (s_fin(siu_pkg::OP_UNSTACK) |->
    st_ff.sp == 16'(st_ff.sp0 - {12'h000, st_ff.cnt}))
    else $error("unstack left wrong stack pointer");
  push_sp_a: assert property (s_fin(siu_pkg::OP_STACK) |->
    st_ff.sp == 16'(st_ff.sp0 + {12'h000, st_ff.cnt}))
    else $error("stack store left wrong stack pointer");
  push_addr_a: assert property (st_ff.state == siu_pkg::ST_PUSH &&
    !st_ff.mem_req |=> o_mem_req && o_mem_we &&
    o_mem_addr == 16'($past(st_ff.sp) + 16'h0001))
    else $error("push address is not sp plus one");
  unstack_and_branch_a: assert property (s_pop_ack ##0
    st_ff.op == siu_pkg::OP_UNSTACK_BR |=> st_ff.pc == $past(i_mem_rdata)
    ##1 st_ff.state == siu_pkg::ST_IDLE)
    else $error("unstack-and-branch pc wrong");
  save_fp_a: assert property (s_fin(siu_pkg::OP_SUB_ENTRY) |=>
    st_ff.fp == $past(st_ff.sp) && ac3_val == $past(st_ff.sp))
    else $error("entry frame pointer wrong");
  exit_fp_a: assert property (s_fin(siu_pkg::OP_SUB_EXIT) |=>
    st_ff.fp == $past(ac3_val) && st_ff.sp == $past(st_ff.sp))
    else $error("exit frame pointer wrong");
endmodule : siu_stack_unit
`default_nettype wire

// >>> testbench/siu_mem_model.sv
// stack memory partner: 256 words, one-cycle ack pulse per request
// assumes req, address and data are held until the ack edge
`timescale 1ns/1ps
`default_nettype none
module siu_mem_model (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_req, // request level
  input wire logic i_we, // write when high
  input wire logic [15:0] i_addr, // word address
  input wire logic [15:0] i_wdata, // write data
  output logic [15:0] o_rdata, // read data, valid with ack only
  output logic o_ack // completion pulse
);
  logic [15:0] mem [0:255];
  logic [1:0] dly_ff;
  logic slow_ff;
  // alternate prompt and slow answers; data line churns outside ack
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      o_rdata <= 16'h0000;
      dly_ff <= 2'h0;
      slow_ff <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
        if (dly_ff == (slow_ff ? 2'h2 : 2'h0)) begin
          o_ack <= 1'b1;
          dly_ff <= 2'h0;
          slow_ff <= ~slow_ff;
          if (i_we) mem[i_addr[7:0]] <= i_wdata;
          else o_rdata <= mem[i_addr[7:0]];
        end else dly_ff <= dly_ff + 2'h1;
      end
    end
  end
endmodule : siu_mem_model
`default_nettype wire

// >>> testbench/siu_stack_unit_tb_top.sv
// stack unit bench: apb master, stack memory model, self-checking tests
// assumes apb ready always comes and command completion seen in status
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end
module siu_stack_unit_tb_top;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, lerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] sw = 16'h0000, maddr, mwd, mrd;
  logic pready, pslverr, mreq, mwe, mack;
  logic load_effective_mode = 0, prot = 0, mx, stb;
  logic [5:0] dev;
  logic [1:0] fn;
  int fails = 0, checks = 0, xl = 0, stbs = 0;
  // count translated memory accesses and flag-only i/o pulses
  always @(posedge clk) begin
    if (mreq && mack && mx) xl++;
    if (stb) stbs++;
  end
  always #20 clk = ~clk;
  siu_stack_unit siu_stack_unit_i (.i_mclk(clk), .i_rst_n(rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_xlat(mx),
    .o_mem_addr(maddr), .o_mem_wdata(mwd), .i_mem_rdata(mrd),
    .i_mem_ack(mack), .i_switch(sw), .i_ld_eff_mode(load_effective_mode), .i_io_prot(prot),
    .o_io_stb(stb), .o_io_dev(dev), .o_io_fn(fn));
  siu_mem_model siu_mem_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_req(mreq),
    .i_we(mwe), .i_addr(maddr), .i_wdata(mwd), .o_rdata(mrd), .o_ack(mack));
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    lerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d}, rd);
  endtask : wr
  task automatic chk(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0000_0000, rd);
    `CHK(rd, {16'h0000, e})
  endtask : chk
  task automatic cmd(input logic [3:0] op, input logic [1:0] s, d);
    wr(siu_pkg::A_CMD, {8'h00, d, s, op});
    do apb(1'b0, siu_pkg::A_STAT, 32'h0000_0000, rd);
    while (rd[0] !== 1'b0);
  endtask : cmd
  task automatic t_push_pop;
    wr(siu_pkg::A_SP, 16'h0010);
    wr(8'h24, 16'h1111);
    wr(8'h28, 16'h2222);
    wr(8'h2c, 16'h3333);
    wr(8'h30, 16'h4444);
    cmd(4'h7, 2'h3, 2'h1);
    chk(siu_pkg::A_SP, 16'h0013);
    `CHK(siu_mem_model_i.mem[8'h11], 16'h4444)
    `CHK(siu_mem_model_i.mem[8'h12], 16'h1111)
    `CHK(siu_mem_model_i.mem[8'h13], 16'h2222)
    chk(8'h30, 16'h4444);
    wr(8'h24, 16'h0000);
    wr(8'h28, 16'h0000);
    wr(8'h30, 16'h0000);
    cmd(4'h4, 2'h1, 2'h3);
    chk(8'h28, 16'h2222);
    chk(8'h24, 16'h1111);
    chk(8'h30, 16'h4444);
    chk(8'h2c, 16'h3333);
    chk(siu_pkg::A_SP, 16'h0010);
    chk(siu_pkg::A_FP, 16'h0000);
    $display("push and pop test done");
  endtask : t_push_pop
  task automatic t_branch_ret;
    siu_mem_model_i.mem[8'h10] = 16'h0200;
    cmd(4'h6, 2'h0, 2'h0);
    chk(siu_pkg::A_PC, 16'h0200);
    chk(siu_pkg::A_SP, 16'h000f);
    wr(siu_pkg::A_PC, 16'h0100);
    cmd(4'h9, 2'h0, 2'h0);
    `CHK(siu_mem_model_i.mem[8'h10], 16'h0102)
    $display("branch and return address test done");
  endtask : t_branch_ret
  task automatic t_misc;
    chk(siu_pkg::A_SL, 16'hffff);
    @(posedge clk) sw <= 16'ha5c3;
    cmd(4'ha, 2'h0, 2'h2);
    chk(8'h2c, 16'ha5c3);
    apb(1'b0, 8'h34, 32'h0000_0000, rd);
    `CHK(lerr, 1'b1)
    $display("reset, switch and unmapped test done");
  endtask : t_misc
  task automatic t_ops;
    wr(8'h10, 16'h0040);
    wr(8'h24, 16'h0001);
    wr(8'h04, 16'h8905);
    cmd(4'h1, 2'h0, 2'h0);
    chk(8'h28, 16'hffff);
    chk(8'h10, 16'h0042);
    wr(8'h24, 16'h0000);
    wr(8'h04, 16'h890b);
    cmd(4'h1, 2'h0, 2'h0);
    chk(8'h28, 16'hffff);
    chk(8'h10, 16'h0044);
    wr(8'h04, 16'h8908);
    cmd(4'h1, 2'h0, 2'h0);
    chk(8'h0c, 16'h0010);
    wr(8'h04, 16'h0025);
    wr(8'h00, 16'h0302);
    wr(8'h0c, 16'h0010);
    `CHK({stbs, dev, fn}, {32'd1, 6'h25, 2'h3})
    cmd(4'h3, 2'h0, 2'h0);
    chk(8'h0c, 16'h0008);
    cmd(4'h9, 2'h0, 2'h0);
    cmd(4'h9, 2'h0, 2'h0);
    `CHK(xl, 1)
    wr(8'h0c, 16'h0004);
    load_effective_mode <= 1'b1;
    cmd(4'h3, 2'h0, 2'h0);
    chk(8'h0c, 16'h0004);
    {load_effective_mode, prot} <= 2'b01;
    cmd(4'h3, 2'h0, 2'h0);
    chk(8'h0c, 16'h0004);
    prot <= 1'b0;
    cmd(4'h3, 2'h0, 2'h0);
    chk(8'h0c, 16'h0000);
    $display("ops test done");
  endtask : t_ops
  task automatic t_frame;
    wr(8'h14, 16'h0020);
    wr(8'h18, 16'h0005);
    wr(8'h1c, 16'h0026);
    wr(8'h20, 16'h0300);
    wr(8'h08, 16'h0003);
    wr(8'h0c, 16'h0002);
    cmd(4'hd, 2'h0, 2'h0);
    `CHK(siu_mem_model_i.mem[8'h24], 16'h0005)
    `CHK(siu_mem_model_i.mem[8'h25], 16'hc444)
    chk(8'h30, 16'h0025);
    chk(8'h14, 16'h0028);
    chk(8'h10, 16'h0300);
    wr(8'h24, 16'h7777);
    cmd(4'hc, 2'h0, 2'h0);
    chk(8'h10, 16'h4444);
    chk(8'h24, 16'h0000);
    chk(8'h18, 16'h0005);
    chk(8'h14, 16'h0020);
    $display("frame test done");
  endtask : t_frame
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_misc;
    t_push_pop;
    t_branch_ret;
    t_ops;
    t_frame;
    conclude;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude;
  end
endmodule : siu_stack_unit_tb_top
`default_nettype wire
